// ===== pkg/fus_pkg.sv
// Functional notes
// - countdown expiry moves to upgrade
// - countdown answers state 3, info, ignores data
// - exec nonzero in countdown reloads, state 3
// - exec zero in countdown reloads, enters upgrade
// - base node supplies both timer values
// - kill anywhere returns idle, state 0
// - safety countdown starts on upgrade entry
// - safety expiry rejects firmware, state 0
// - confirm in upgrade accepts firmware, state 0
// - upgrade answers state 4, info, ignores data
// - exec in upgrade answers 0, no change
// - only init leaves idle, to receiving
// - crc ok after full image enters complete
// - crc fail drops image, stays receiving
// - complete exec: zero upgrade, else countdown
// - state codes 0 to 4 reported
// - sixteen-bit second counters
package fus_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned TICK_SECONDS = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_SECONDS;
  localparam int          TICK_W       = 25;
  localparam int          TIMER_W      = 16;
  localparam logic [15:0] TIMER_RESET  = 16'h0000;

  // ==========================================
  // state codes reported in state replies
  localparam logic [2:0] CODE_IDLE      = 3'h0;
  localparam logic [2:0] CODE_RECEIVING = 3'h1;
  localparam logic [2:0] CODE_COMPLETE  = 3'h2;
  localparam logic [2:0] CODE_COUNTDOWN = 3'h3;
  localparam logic [2:0] CODE_UPGRADE   = 3'h4;

  // ==========================================
  // packet kinds presented by the parser
  typedef enum logic [3:0] {
    PKT_INIT, PKT_EXEC, PKT_CONFIRM, PKT_STATE, PKT_KILL,
    PKT_INFO, PKT_MISS, PKT_CRC, PKT_DATA
  } fus_pkt_e;

  typedef enum logic [1:0] {
    RSP_STATE, RSP_INFO, RSP_CRC, RSP_MISS
  } fus_rsp_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECEIVING, ST_COMPLETE, ST_COUNTDOWN, ST_UPGRADE
  } fus_state_e;
endpackage : fus_pkg

// ===== design/fus_tick.sv
`timescale 1ns/10ps
`default_nettype none
module fus_tick (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic syncClear,
  output logic      tick
);
  typedef struct packed {
    logic [fus_pkg::TICK_W-1:0] count;
    logic                       tick;
  } fus_tick_s;
  fus_tick_s r;
  fus_tick_s next_r;

  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (syncClear) begin
      next_r.count = '0;
    end else if (r.count == fus_pkg::TICK_W'(fus_pkg::TICK_CYCLES - 1)) begin
      next_r.count = '0;
      next_r.tick  = 1'b1;
    end else begin
      next_r.count = r.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : fus_tick
`default_nettype wire

// ===== design/fus_timer.sv
`timescale 1ns/10ps
`default_nettype none
// one seconds down-counter; load wins over the tick
module fus_timer (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        syncClear,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  input  wire logic        run,
  input  wire logic        tick,
  output logic      [15:0] count,
  output logic             zero
);
  typedef struct packed {
    logic [15:0] count;
  } fus_timer_s;
  fus_timer_s r;
  fus_timer_s next_r;

  always_comb begin
    next_r = r;
    if (syncClear) begin
      next_r.count = fus_pkg::TIMER_RESET;
    end else if (load) begin
      next_r.count = loadValue;
    end else if (run && tick && r.count != 16'h0000) begin
      next_r.count = r.count - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.count;
  assign zero  = (r.count == 16'h0000);
endmodule : fus_timer
`default_nettype wire

// ===== design/fus_core.sv
`timescale 1ns/10ps
`default_nettype none
module fus_core (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             syncReset,
  input  wire logic             pktValid,
  input  wire fus_pkg::fus_pkt_e pktKind,
  input  wire logic [15:0]      execRestart,
  input  wire logic [15:0]      execSafety,
  input  wire logic             imageComplete,
  input  wire logic             crcOk,
  output logic                  rspValid,
  output fus_pkg::fus_rsp_e     rspKind,
  output logic [2:0]            rspStateCode,
  output logic                  rspCrcOk,
  output logic                  imageDrop,
  output logic                  dataAccept,
  output logic                  fwAccept,
  output logic                  fwReject,
  output logic                  runNewFw,
  output logic [2:0]            stateCode,
  output logic [15:0]           restartLeft,
  output logic [15:0]           safetyLeft
);
  // ==========================================
  // state
  typedef struct packed {
    fus_pkg::fus_state_e state;
    logic                rspValid;
    fus_pkg::fus_rsp_e   rspKind;
    logic [2:0]          rspStateCode;
    logic                rspCrcOk;
    logic                imageDrop;
    logic                dataAccept;
    logic                fwAccept;
    logic                fwReject;
    logic                restartLoad;
    logic                safetyLoad;
    logic [15:0]         restartVal;
    logic [15:0]         safetyVal;
    logic [15:0]         safetyHold;
    logic [2:0]          stateCode;
    logic                runNewFw;
    logic [15:0]         restartLeft;
    logic [15:0]         safetyLeft;
  } fus_core_s;
  fus_core_s r;
  fus_core_s next_r;

  logic        tick;
  logic [15:0] restartCount;
  logic [15:0] safetyCount;
  logic        restartZero;
  logic        safetyZero;
  logic [15:0] safetyLoadValue;

  // ==========================================
  // one-second enable and the two countdowns
  fus_tick u_tick (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .syncClear (syncReset),
    .tick      (tick)
  );

  fus_timer u_restart (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .syncClear (syncReset),
    .load      (r.restartLoad),
    .loadValue (r.restartVal),
    .run       (r.state == fus_pkg::ST_COUNTDOWN),
    .tick      (tick),
    .count     (restartCount),
    .zero      (restartZero)
  );

  // safety value is parked and only loaded into the counter on upgrade entry
  fus_timer u_safety (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .syncClear (syncReset),
    .load      (r.safetyLoad),
    .loadValue (safetyLoadValue),
    .run       (r.state == fus_pkg::ST_UPGRADE),
    .tick      (tick),
    .count     (safetyCount),
    .zero      (safetyZero)
  );

  // a zero restart loads the counter in the very cycle the value would be parked
  assign safetyLoadValue = r.restartLoad ? r.safetyVal : r.safetyHold;

  // ==========================================
  // next state
  function automatic logic [2:0] codeOf(input fus_pkg::fus_state_e s);
    case (s)
      fus_pkg::ST_RECEIVING: codeOf = fus_pkg::CODE_RECEIVING;
      fus_pkg::ST_COMPLETE:  codeOf = fus_pkg::CODE_COMPLETE;
      fus_pkg::ST_COUNTDOWN: codeOf = fus_pkg::CODE_COUNTDOWN;
      fus_pkg::ST_UPGRADE:   codeOf = fus_pkg::CODE_UPGRADE;
      default:               codeOf = fus_pkg::CODE_IDLE;
    endcase
  endfunction : codeOf

  always_comb begin
    next_r              = r;
    next_r.rspValid     = 1'b0;
    next_r.rspCrcOk     = 1'b0;
    next_r.imageDrop    = 1'b0;
    next_r.dataAccept   = 1'b0;
    next_r.fwAccept     = 1'b0;
    next_r.fwReject     = 1'b0;
    next_r.restartLoad  = 1'b0;
    next_r.safetyLoad   = 1'b0;
    next_r.rspKind      = fus_pkg::RSP_STATE;
    next_r.rspStateCode = codeOf(r.state);

    // a load issued last cycle has not yet reached the counter, so hold off
    if (r.state == fus_pkg::ST_COUNTDOWN && !pktValid && !r.restartLoad
        && restartZero) begin
      next_r.state      = fus_pkg::ST_UPGRADE;
      next_r.safetyLoad = 1'b1;
    end else if (r.state == fus_pkg::ST_UPGRADE && !pktValid && !r.safetyLoad
                 && safetyZero) begin
      next_r.state        = fus_pkg::ST_IDLE;
      next_r.rspValid     = 1'b1;
      next_r.rspStateCode = fus_pkg::CODE_IDLE;
      next_r.fwReject     = 1'b1;
    end else if (pktValid) begin
      next_r.rspValid = 1'b1;
      if (pktKind == fus_pkg::PKT_KILL) begin
        next_r.state        = fus_pkg::ST_IDLE;
        next_r.rspStateCode = fus_pkg::CODE_IDLE;
        next_r.fwReject     = (r.state == fus_pkg::ST_UPGRADE);
      end else if (pktKind == fus_pkg::PKT_INFO) begin
        next_r.rspKind = fus_pkg::RSP_INFO;
      end else if (pktKind == fus_pkg::PKT_DATA) begin
        next_r.rspValid   = 1'b0;
        next_r.dataAccept = (r.state == fus_pkg::ST_RECEIVING);
      end else begin
        case (r.state)
          fus_pkg::ST_IDLE: begin
            if (pktKind == fus_pkg::PKT_INIT) begin
              next_r.state        = fus_pkg::ST_RECEIVING;
              next_r.rspStateCode = fus_pkg::CODE_RECEIVING;
            end
          end
          fus_pkg::ST_RECEIVING: begin
            if (pktKind == fus_pkg::PKT_MISS) begin
              next_r.rspKind = fus_pkg::RSP_MISS;
            end else if (pktKind == fus_pkg::PKT_CRC && imageComplete) begin
              next_r.rspKind  = fus_pkg::RSP_CRC;
              next_r.rspCrcOk = crcOk;
              if (crcOk) begin
                next_r.state = fus_pkg::ST_COMPLETE;
              end else begin
                next_r.imageDrop = 1'b1;
              end
            end
          end
          fus_pkg::ST_COMPLETE: begin
            if (pktKind == fus_pkg::PKT_EXEC) begin
              next_r.restartLoad = 1'b1;
              next_r.restartVal  = execRestart;
              next_r.safetyVal   = execSafety;
              if (execRestart == 16'h0000) begin
                next_r.state        = fus_pkg::ST_UPGRADE;
                next_r.safetyLoad   = 1'b1;
                next_r.rspStateCode = fus_pkg::CODE_UPGRADE;
              end else begin
                next_r.state        = fus_pkg::ST_COUNTDOWN;
                next_r.rspStateCode = fus_pkg::CODE_COUNTDOWN;
              end
            end
          end
          fus_pkg::ST_COUNTDOWN: begin
            if (pktKind == fus_pkg::PKT_EXEC) begin
              next_r.restartLoad = 1'b1;
              next_r.restartVal  = execRestart;
              next_r.safetyVal   = execSafety;
              if (execRestart == 16'h0000) begin
                next_r.state        = fus_pkg::ST_UPGRADE;
                next_r.safetyLoad   = 1'b1;
                next_r.rspStateCode = fus_pkg::CODE_UPGRADE;
              end else begin
                next_r.rspStateCode = fus_pkg::CODE_COUNTDOWN;
              end
            end else begin
              next_r.rspStateCode = fus_pkg::CODE_COUNTDOWN;
            end
          end
          fus_pkg::ST_UPGRADE: begin
            if (pktKind == fus_pkg::PKT_EXEC) begin
              next_r.rspStateCode = fus_pkg::CODE_IDLE;
            end else if (pktKind == fus_pkg::PKT_CONFIRM) begin
              next_r.state        = fus_pkg::ST_IDLE;
              next_r.rspStateCode = fus_pkg::CODE_IDLE;
              next_r.fwAccept     = 1'b1;
            end else begin
              next_r.rspStateCode = fus_pkg::CODE_UPGRADE;
            end
          end
          default: begin
            next_r.state = fus_pkg::ST_IDLE;
          end
        endcase
      end
    end

    if (r.restartLoad) begin
      next_r.safetyHold = r.safetyVal;
    end
    // counters are shown one cycle late; sync reset clears the copies at once
    next_r.restartLeft = restartCount;
    next_r.safetyLeft  = safetyCount;

    if (syncReset) begin
      next_r       = '0;
      next_r.state = fus_pkg::ST_IDLE;
    end
    next_r.stateCode = codeOf(next_r.state);
    next_r.runNewFw  = (next_r.state == fus_pkg::ST_UPGRADE);
  end

  // ==========================================
  // registers and outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rspValid     = r.rspValid;
  assign rspKind      = r.rspKind;
  assign rspStateCode = r.rspStateCode;
  assign rspCrcOk     = r.rspCrcOk;
  assign imageDrop    = r.imageDrop;
  assign dataAccept   = r.dataAccept;
  assign fwAccept     = r.fwAccept;
  assign fwReject     = r.fwReject;
  assign runNewFw     = r.runNewFw;
  assign stateCode    = r.stateCode;
  assign restartLeft  = r.restartLeft;
  assign safetyLeft   = r.safetyLeft;
endmodule : fus_core
`default_nettype wire

// ===== sim/fus_base_node.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// base node: one control packet per call
module fus_base_node (
  input  wire logic             ref_clk,
  output var logic              pktValid,
  output var fus_pkg::fus_pkt_e pktKind,
  output var logic [15:0]       execRestart,
  output var logic [15:0]       execSafety
);
  initial begin
    pktValid    = 1'b0;
    pktKind     = fus_pkg::PKT_STATE;
    execRestart = 16'h0000;
    execSafety  = 16'h0000;
  end

  task automatic send(input fus_pkg::fus_pkt_e k, input logic [15:0] r, input logic [15:0] s);
    @(posedge ref_clk);
    pktValid    <= 1'b1;
    pktKind     <= k;
    execRestart <= r;
    execSafety  <= s;
    @(posedge ref_clk);
    pktValid    <= 1'b0;
    // fields go stale once the packet is gone, so never repeat them
    execRestart <= ~r;
    execSafety  <= ~s;
  endtask : send
endmodule : fus_base_node
`default_nettype wire

// ===== sim/fus_core_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fus_core_asserts (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              syncReset,
  input wire logic              pktValid,
  input wire fus_pkg::fus_pkt_e pktKind,
  input wire logic [15:0]       execRestart,
  input wire logic              imageComplete,
  input wire logic              crcOk,
  input wire logic              rspValid,
  input wire fus_pkg::fus_rsp_e rspKind,
  input wire logic [2:0]        rspStateCode,
  input wire logic              rspCrcOk,
  input wire logic              fwAccept,
  input wire logic              fwReject,
  input wire logic [2:0]        stateCode,
  input wire logic [15:0]       restartLeft,
  input wire logic [15:0]       safetyLeft
);
  logic take, inIdle, inCd, inUp, exec;
  assign take   = pktValid && !syncReset;
  assign inIdle = stateCode == 3'h0;
  assign inCd   = stateCode == 3'h3;
  assign inUp   = stateCode == 3'h4;
  assign exec   = take && pktKind == fus_pkg::PKT_EXEC;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================
  // replies
  AST_ANSWER: assert property (take && pktKind != fus_pkg::PKT_DATA |=> rspValid)
    else $error("packet not answered");
  AST_DATA_QUIET: assert property (take && pktKind == fus_pkg::PKT_DATA
    |=> !rspValid) else $error("data packet answered");
  AST_INFO: assert property (take && pktKind == fus_pkg::PKT_INFO
    |=> rspKind == fus_pkg::RSP_INFO) else $error("info request got no info reply");
  AST_CD_STATE: assert property (take && inCd && pktKind inside {fus_pkg::PKT_STATE,
    fus_pkg::PKT_MISS, fus_pkg::PKT_CRC, fus_pkg::PKT_INIT, fus_pkg::PKT_CONFIRM}
    |=> rspKind == fus_pkg::RSP_STATE && rspStateCode == 3'h3 && inCd)
    else $error("countdown reply wrong");
  AST_UP_STATE: assert property (take && inUp && pktKind inside {fus_pkg::PKT_STATE,
    fus_pkg::PKT_MISS, fus_pkg::PKT_CRC, fus_pkg::PKT_INIT}
    |=> rspKind == fus_pkg::RSP_STATE && rspStateCode == 3'h4 && inUp)
    else $error("upgrade reply wrong");
  AST_CRC: assert property (take && stateCode == 3'h1
    && pktKind == fus_pkg::PKT_CRC
    && imageComplete |=> rspKind == fus_pkg::RSP_CRC && rspCrcOk == $past(crcOk)
    && (stateCode == 3'h2) == $past(crcOk)) else $error("crc outcome wrong");

  // ==========================================
  // transitions
  AST_KILL: assert property (take && pktKind == fus_pkg::PKT_KILL
    |=> rspStateCode == 3'h0 && inIdle) else $error("kill not to idle");
  AST_IDLE_STAY: assert property (take && inIdle && pktKind != fus_pkg::PKT_INIT
    |=> inIdle) else $error("idle left without init");
  // the counter copy shows a load two cycles after the taking edge
  AST_RELOAD: assert property (exec && (inCd || stateCode == 3'h2)
    && execRestart != 16'h0
    |=> inCd && rspStateCode == 3'h3 ##2 restartLeft == $past(execRestart, 3))
    else $error("restart reload wrong");
  AST_EXEC_ZERO: assert property (exec && (inCd || stateCode == 3'h2)
    && execRestart == 16'h0 |=> inUp && rspStateCode == 3'h4)
    else $error("zero restart not to upgrade");
  AST_UP_EXEC: assert property (exec && inUp |=> inUp && rspStateCode == 3'h0)
    else $error("exec in upgrade wrong");
  AST_CONFIRM: assert property (take && inUp && pktKind == fus_pkg::PKT_CONFIRM
    |=> fwAccept && !fwReject && inIdle && rspStateCode == 3'h0)
    else $error("confirm not accepted");
  AST_REJECT: assert property (fwReject |-> rspValid && rspStateCode == 3'h0
    && inIdle && $past(inUp)) else $error("reject outside upgrade exit");
  AST_SYNC: assert property (syncReset |=> inIdle && restartLeft == 16'h0
    && safetyLeft == 16'h0 && !rspValid) else $error("sync reset incomplete");
endmodule : fus_core_asserts

bind fus_core fus_core_asserts u_asserts (.ref_clk, .reset_n, .syncReset, .pktValid, .pktKind,
  .execRestart, .imageComplete, .crcOk, .rspValid, .rspKind, .rspStateCode, .rspCrcOk,
  .fwAccept, .fwReject, .stateCode, .restartLeft, .safetyLeft);
`default_nettype wire

// ===== sim/firmware_upgrade_state_machine_bench.sv
`timescale 1ns/10ps
`default_nettype none
module firmware_upgrade_state_machine_bench;
  typedef struct packed {
    fus_pkg::fus_pkt_e kind;
    logic [15:0]       rst;
    logic [15:0]       saf;
    logic [1:0]        ic;
    fus_pkg::fus_rsp_e rk;
    logic [2:0]        code;
    logic [2:0]        st;
  } fus_row_s;
  logic              ref_clk, reset_n, syncReset, imageComplete, crcOk, pktValid;
  logic              rspValid, fwReject, rspCrcOk, imageDrop, dataAccept, runNewFw;
  fus_pkg::fus_pkt_e pktKind;
  fus_pkg::fus_rsp_e rspKind;
  logic [2:0]        rspStateCode, stateCode;
  logic [15:0]       execRestart, execSafety, restartLeft, safetyLeft;
  int                n_fail = 0;
  int                num_checks = 0;
  int                cycles = 0;
  int                n;
  fus_row_s          rows [18] = '{
    '{fus_pkg::PKT_STATE, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h0},
    '{fus_pkg::PKT_DATA, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h0},
    '{fus_pkg::PKT_INIT, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h1, 3'h1},
    '{fus_pkg::PKT_CRC, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h1, 3'h1},
    '{fus_pkg::PKT_MISS, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_MISS, 3'h0, 3'h1},
    '{fus_pkg::PKT_DATA, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h1},
    '{fus_pkg::PKT_CRC, 16'h0, 16'h0, 2'h2, fus_pkg::RSP_CRC, 3'h0, 3'h1},
    '{fus_pkg::PKT_CRC, 16'h0, 16'h0, 2'h3, fus_pkg::RSP_CRC, 3'h0, 3'h2},
    '{fus_pkg::PKT_CONFIRM, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h2, 3'h2},
    '{fus_pkg::PKT_EXEC, 16'h5, 16'h7, 2'h0, fus_pkg::RSP_STATE, 3'h3, 3'h3},
    '{fus_pkg::PKT_INIT, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h3, 3'h3},
    '{fus_pkg::PKT_INFO, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_INFO, 3'h0, 3'h3},
    '{fus_pkg::PKT_EXEC, 16'h6, 16'h9, 2'h0, fus_pkg::RSP_STATE, 3'h3, 3'h3},
    '{fus_pkg::PKT_EXEC, 16'h0, 16'h9, 2'h0, fus_pkg::RSP_STATE, 3'h4, 3'h4},
    '{fus_pkg::PKT_CRC, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h4, 3'h4},
    '{fus_pkg::PKT_DATA, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h4},
    '{fus_pkg::PKT_EXEC, 16'h1, 16'h1, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h4},
    '{fus_pkg::PKT_CONFIRM, 16'h0, 16'h0, 2'h0, fus_pkg::RSP_STATE, 3'h0, 3'h0}};

  fus_base_node u_base (.ref_clk, .pktValid, .pktKind, .execRestart, .execSafety);
  fus_core u_dut (.ref_clk, .reset_n, .syncReset, .pktValid, .pktKind, .execRestart,
    .execSafety, .imageComplete, .crcOk, .rspValid, .rspKind, .rspStateCode, .rspCrcOk,
    .imageDrop, .dataAccept, .fwAccept(), .fwReject, .runNewFw, .stateCode,
    .restartLeft, .safetyLeft);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // the final crc request is what lets the node leave receiving
  task automatic reach(input logic [15:0] r, input logic [15:0] s);
    u_base.send(fus_pkg::PKT_INIT, 16'h0, 16'h0);
    u_base.send(fus_pkg::PKT_CRC, 16'h0, 16'h0);
    u_base.send(fus_pkg::PKT_EXEC, r, s);
  endtask : reach

  // ==========================================
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    reset_n       = 1'b0;
    syncReset     = 1'b0;
    imageComplete = 1'b0;
    crcOk         = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      {imageComplete, crcOk} <= rows[i].ic;
      u_base.send(rows[i].kind, rows[i].rst, rows[i].saf);
      #1;
      chk(rspValid, rows[i].kind != fus_pkg::PKT_DATA, "reply");
      if (rows[i].kind != fus_pkg::PKT_DATA) begin
        chk(rspKind, rows[i].rk, "reply kind");
        if (rows[i].rk == fus_pkg::RSP_STATE) chk(rspStateCode, rows[i].code, "code");
        if (rows[i].rk == fus_pkg::RSP_CRC) chk(rspCrcOk, rows[i].ic[0], "crc result");
      end
      chk(dataAccept, rows[i].kind == fus_pkg::PKT_DATA && rows[i].st == 3'h1, "store");
      chk(imageDrop, rows[i].kind == fus_pkg::PKT_CRC && rows[i].ic == 2'h2, "drop");
      chk(runNewFw, rows[i].st == 3'h4, "run new");
      chk(stateCode, rows[i].st, "state");
    end
    $display("test table done");
    @(posedge ref_clk);
    imageComplete <= 1'b1;
    crcOk         <= 1'b1;
    reach(16'h0000, 16'h0064);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(safetyLeft, 16'h0064, "safety load");
    chk(runNewFw, 1'b1, "running new");
    u_base.send(fus_pkg::PKT_KILL, 16'h0, 16'h0);
    #1;
    chk(fwReject, 1'b1, "kill reject");
    chk(stateCode, 3'h0, "kill idle");
    $display("test kill done");
    // zero safety runs out a couple of cycles after entry
    reach(16'h0000, 16'h0000);
    n = 0;
    while (fwReject !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(fwReject, 1'b1, "expiry");
    chk(stateCode, 3'h0, "expiry idle");
    $display("test expiry done");
    reach(16'hffff, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(restartLeft, 16'hffff, "restart width");
    @(posedge ref_clk);
    syncReset <= 1'b1;
    @(posedge ref_clk);
    syncReset <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(stateCode, 3'h0, "sync idle");
    chk(restartLeft, 16'h0000, "sync clear");
    u_base.send(fus_pkg::PKT_INIT, 16'h0, 16'h0);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk(stateCode, 3'h0, "async idle");
    $display("test reset done");
    test_done();
  end
endmodule : firmware_upgrade_state_machine_bench
`default_nettype wire
